// File: ocs_clk_rx.sv
// downstream clock receiver model: counts rising edges and shortest run
// assumes received clocks are sampled on the master clock
`timescale 1ns/100ps
module ocs_clk_rx #(
  parameter int NL = 9
) (
  // sampling clock
  input wire logic clk_sys,
  // received clocks and statistics clear
  input wire logic [NL-1:0] clk_in,
  input wire logic clr,
  // statistics per lane
  output logic [15:0] edges [NL],
  output logic [15:0] min_run [NL]
);
  logic [NL-1:0] prev_reg;
  logic [NL-1:0] armed_reg;
  logic [15:0] run_reg [NL];

  // first partial run after clear is never counted as a runt
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < NL; i++) begin
      prev_reg[i] <= clk_in[i];
      if (clr) begin
        edges[i] <= 16'h0;
        min_run[i] <= 16'hffff;
        armed_reg[i] <= 1'b0;
        run_reg[i] <= 16'h1;
      end else if (clk_in[i] != prev_reg[i]) begin
        if (clk_in[i]) begin
          edges[i] <= edges[i] + 16'h1;
        end
        if (armed_reg[i] && run_reg[i] < min_run[i]) begin
          min_run[i] <= run_reg[i];
        end
        armed_reg[i] <= 1'b1;
        run_reg[i] <= 16'h1;
      end else begin
        run_reg[i] <= run_reg[i] + 16'h1;
      end
    end
  end
endmodule

// File: ocs_dfs_synth.sv
// one phase-accumulator frequency synthesizer
// assumes clk_sys is the master clock and rst_n is already synchronised
`timescale 1ns/100ps
module ocs_dfs_synth
  import ocs_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // controls and results
  ocs_synth_if.synth s
);

  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] acc_next;
  logic src_reg;
  logic wrap_reg;
  logic [PH_W-1:0] phase_reg;
  logic signed [ADJ_W-1:0] adj;
  logic signed [55:0] prod;
  logic [ACC_W-1:0] inc;
  logic [ACC_W:0] sum;
  logic wrap;

  // path frequency steering on the nominal increment
  assign adj = src_reg ? s.aux_adj : s.main_adj;
  assign prod = 56'($signed({1'b0, s.nominal})) * 56'(adj);
  assign inc = s.nominal + prod[ADJ_SHIFT +: ACC_W];
  assign sum = {1'b0, acc_reg} + {1'b0, inc};
  assign wrap = sum[ACC_W] && !s.hold;
  assign acc_next = s.hold ? ACC_RST : sum[ACC_W-1:0];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= ACC_RST;
      src_reg <= 1'b0;
      wrap_reg <= 1'b0;
      phase_reg <= '0;
    end else begin
      acc_reg <= acc_next;
      wrap_reg <= wrap;
      // source swaps only at a period boundary
      if (wrap) begin
        src_reg <= s.src_aux_req;
        phase_reg <= acc_next[ACC_W-1 -: PH_W];
      end
    end
  end

  assign s.acc = acc_reg;
  assign s.wrap = wrap_reg;
  assign s.phase = phase_reg;
  assign s.src_aux_eff = src_reg;

  chk_src_swap_boundary: assert property (@(posedge clk_sys)
    disable iff (!rst_n) !wrap |=> $stable(src_reg))
    else $error("source changed away from a period boundary");

  chk_acc_advances: assert property (@(posedge clk_sys)
    disable iff (!rst_n) !s.hold && !wrap |=> acc_reg > $past(acc_reg))
    else $error("accumulator failed to advance");

endmodule

// File: ocs_output_clock_synth.sv
// output clock synthesis and routing: path synthesizers, seven output
// synthesizers, frame sync generation and differential output format
// assumes configuration ports come from logic on clk_sys
`timescale 1ns/100ps

// Summary of operation
// - seven output clocks each tunable and sourced from main or aux path
// - frame sync at 8 kHz and multiframe sync at 2 kHz
// - frame and multiframe sync pulse width and polarity are programmable
// - per differential output bits choose lvds, lvpecl level or off
// - synthesizers add an increment to a phase accumulator per master clock
// - accumulator phase code places the edge at each wrap between master clock edges; only dig1 outputs it
// - aux path one synthesizer for outputs and feedback; main also one, feedback offset from it
// - only main feedback carries build-out and phase offset
// - feedback synthesizer is always driven by its own path forward one
// - seven output synths: five selectable, two fixed to main
// - lock aux to main forces every output synthesizer onto main
// - frame sync synth on main unless independent mode chosen
// - 2k/8k synth source by its select bit and lock aux to main
// - each digital-rate synth by its select bit, overridden by lock
// - first digital rate by family bit plus two-bit multiplier
// - second digital rate by alternate bit, family bit and two-bit field
// - main apll reference synthesizers always on main path
// - aux apll reference by its to-main bit and lock aux to main
// - aux apll code 0000 and to-main 0 powers it down, outputs low
// - multiplier codes give e1 and ds1 multiples as tabulated
module ocs_output_clock_synth
  import ocs_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // path frequency and phase steering
  input wire logic signed [ADJ_W-1:0] main_path_adj,
  input wire logic signed [ADJ_W-1:0] aux_path_adj,
  input wire logic [ACC_W-1:0] main_phase_offset,
  // source selection
  input wire logic lock_aux_to_main,
  input wire logic framesync_independent,
  input wire logic lowrate_synth_source,
  input wire logic digrate_one_source,
  input wire logic digrate_two_source,
  input wire logic aux_apll_to_main,
  // frequency selection
  input wire logic digrate_one_family,
  input wire logic [1:0] digrate_one_multiplier,
  input wire logic digrate_two_alt_freq,
  input wire logic digrate_two_family,
  input wire logic [1:0] digrate_two_multiplier,
  input wire logic [3:0] aux_apll_freq_sel,
  input wire logic [ACC_W-1:0] main_apll_inc,
  input wire logic [ACC_W-1:0] main_apll2_inc,
  input wire logic [ACC_W-1:0] aux_apll_inc,
  // frame sync shape
  input wire logic [7:0] fs_width,
  input wire logic fs_invert,
  input wire logic [7:0] mfs_width,
  input wire logic mfs_invert,
  // differential output format
  input wire logic [2*NDIFF-1:0] diff_output_format_sel,
  // path clocks
  output logic main_fwd_clk,
  output logic main_fb_clk,
  output logic aux_fwd_clk,
  output logic aux_fb_clk,
  // sync outputs
  output logic frame_sync_out,
  output logic multiframe_sync_out,
  output logic lowrate_8k_out,
  output logic lowrate_2k_out,
  // digital rate and apll reference clocks
  output logic dig1_clk,
  output logic [PH_W-1:0] dig1_edge_phase,
  output logic dig2_clk,
  output logic main_apll_ref,
  output logic main_apll2_ref,
  output logic aux_apll_ref,
  output logic aux_apll_pwr_dn,
  // differential outputs
  output logic [NDIFF-1:0] diff_p,
  output logic [NDIFF-1:0] diff_n,
  output logic [NDIFF-1:0] diff_en,
  output logic [NDIFF-1:0] diff_pecl,
  // effective sources: lowrate, dig1, dig2, aux apll (1 = aux)
  output logic [3:0] src_aux_status
);

  logic rst_meta_reg;
  logic rst_s_n;

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_s_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_s_n <= rst_meta_reg;
    end
  end

  ocs_synth_if sif [NSYN] ();

  genvar gi;
  generate
    for (gi = 0; gi < NSYN; gi++) begin : g_syn
      ocs_dfs_synth u_syn (
        .clk_sys(clk_sys),
        .rst_n(rst_s_n),
        .s(sif[gi])
      );
      assign sif[gi].main_adj = main_path_adj;
      assign sif[gi].aux_adj = aux_path_adj;
    end
  endgenerate

  // source requests
  logic fs_src_aux;
  logic lr_src_aux;
  logic d1_src_aux;
  logic d2_src_aux;
  logic ax_src_aux;
  logic ax_off;

  assign fs_src_aux = framesync_independent && !lock_aux_to_main;
  assign lr_src_aux = lowrate_synth_source && !lock_aux_to_main;
  assign d1_src_aux = digrate_one_source && !lock_aux_to_main;
  assign d2_src_aux = digrate_two_source && !lock_aux_to_main;
  assign ax_src_aux = !aux_apll_to_main && !lock_aux_to_main;
  assign ax_off = (aux_apll_freq_sel == AUX_APLL_OFF)
    && !aux_apll_to_main;

  // frequency words
  logic [ACC_W-1:0] d1_inc;
  logic [ACC_W-1:0] d2_base;
  logic [ACC_W-1:0] d2_alt;
  logic [ACC_W-1:0] d2_inc;

  assign d1_inc = digrate_one_family ? INC_DS1[digrate_one_multiplier]
    : INC_E1[digrate_one_multiplier];
  assign d2_base = digrate_two_family ? INC_DS1[digrate_two_multiplier]
    : INC_E1[digrate_two_multiplier];
  assign d2_alt = digrate_two_family ?
    (digrate_two_multiplier[0] ? INC_3888 : INC_1944)
    : (digrate_two_multiplier[1] ? INC_10M : INC_6312);
  assign d2_inc = digrate_two_alt_freq ? d2_alt : d2_base;

  // path forward synthesizers
  assign sif[S_MAIN_FWD].nominal = INC_PATH;
  assign sif[S_MAIN_FWD].src_aux_req = 1'b0;
  assign sif[S_MAIN_FWD].hold = 1'b0;
  assign sif[S_AUX_FWD].nominal = INC_PATH;
  assign sif[S_AUX_FWD].src_aux_req = 1'b1;
  assign sif[S_AUX_FWD].hold = 1'b0;

  // output synthesizers
  assign sif[S_FRAME_SYNC_OUT].nominal = INC_FS;
  assign sif[S_FRAME_SYNC_OUT].src_aux_req = fs_src_aux;
  assign sif[S_FRAME_SYNC_OUT].hold = 1'b0;
  assign sif[S_LOWRATE].nominal = INC_FS;
  assign sif[S_LOWRATE].src_aux_req = lr_src_aux;
  assign sif[S_LOWRATE].hold = 1'b0;
  assign sif[S_DIG1].nominal = d1_inc;
  assign sif[S_DIG1].src_aux_req = d1_src_aux;
  assign sif[S_DIG1].hold = 1'b0;
  assign sif[S_DIG2].nominal = d2_inc;
  assign sif[S_DIG2].src_aux_req = d2_src_aux;
  assign sif[S_DIG2].hold = 1'b0;
  assign sif[S_APLL_MAIN].nominal = main_apll_inc;
  assign sif[S_APLL_MAIN].src_aux_req = 1'b0;
  assign sif[S_APLL_MAIN].hold = 1'b0;
  assign sif[S_APLL_MAIN2].nominal = main_apll2_inc;
  assign sif[S_APLL_MAIN2].src_aux_req = 1'b0;
  assign sif[S_APLL_MAIN2].hold = 1'b0;
  assign sif[S_APLL_AUX].nominal = aux_apll_inc;
  assign sif[S_APLL_AUX].src_aux_req = ax_src_aux;
  assign sif[S_APLL_AUX].hold = ax_off;

  // feedback: main adds offset to its forward phase, aux reuses forward
  logic [ACC_W-1:0] main_fb_acc;
  assign main_fb_acc = sif[S_MAIN_FWD].acc + main_phase_offset;

  // frame and multiframe sync
  logic fs_wrap;
  logic [1:0] frame_cnt_reg;
  logic [7:0] fs_cnt_reg;
  logic [7:0] mfs_cnt_reg;
  logic lr_wrap;
  logic [1:0] lr_div_reg;
  logic fs_active;
  logic mfs_active;
  logic mf_start;

  assign fs_wrap = sif[S_FRAME_SYNC_OUT].wrap;
  assign mf_start = fs_wrap && (frame_cnt_reg == MF_LAST);
  assign fs_active = fs_cnt_reg != 8'h00;
  assign mfs_active = mfs_cnt_reg != 8'h00;
  assign lr_wrap = sif[S_LOWRATE].wrap;

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      frame_cnt_reg <= 2'h0;
      fs_cnt_reg <= 8'h00;
      mfs_cnt_reg <= 8'h00;
      lr_div_reg <= 2'h0;
    end else begin
      if (fs_wrap) begin
        frame_cnt_reg <= frame_cnt_reg + 2'h1;
      end
      if (fs_wrap) begin
        fs_cnt_reg <= fs_width;
      end else if (fs_active) begin
        fs_cnt_reg <= fs_cnt_reg - 8'h01;
      end
      if (mf_start) begin
        mfs_cnt_reg <= mfs_width;
      end else if (mfs_active) begin
        mfs_cnt_reg <= mfs_cnt_reg - 8'h01;
      end
      if (lr_wrap) begin
        lr_div_reg <= lr_div_reg + 2'h1;
      end
    end
  end

  // differential format decode
  logic [NDIFF-1:0] diff_src;
  logic [NDIFF-1:0] fmt_on;
  logic [NDIFF-1:0] fmt_pecl;

  assign diff_src = {sif[S_DIG2].acc[ACC_W-1],
    sif[S_APLL_AUX].acc[ACC_W-1] && !ax_off,
    sif[S_APLL_MAIN2].acc[ACC_W-1],
    sif[S_APLL_MAIN].acc[ACC_W-1]};
  generate
    for (gi = 0; gi < NDIFF; gi++) begin : g_fmt
      assign fmt_on[gi] = (diff_output_format_sel[2*gi +: 2] == FMT_LVDS)
        || (diff_output_format_sel[2*gi +: 2] == FMT_PECL);
      assign fmt_pecl[gi] =
        diff_output_format_sel[2*gi +: 2] == FMT_PECL;
    end
  endgenerate

  // registered outputs
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      main_fwd_clk <= 1'b0;
      main_fb_clk <= 1'b0;
      aux_fwd_clk <= 1'b0;
      aux_fb_clk <= 1'b0;
      frame_sync_out <= 1'b0;
      multiframe_sync_out <= 1'b0;
      lowrate_8k_out <= 1'b0;
      lowrate_2k_out <= 1'b0;
      dig1_clk <= 1'b0;
      dig1_edge_phase <= '0;
      dig2_clk <= 1'b0;
      main_apll_ref <= 1'b0;
      main_apll2_ref <= 1'b0;
      aux_apll_ref <= 1'b0;
      aux_apll_pwr_dn <= 1'b0;
      diff_p <= '0;
      diff_n <= '0;
      diff_en <= '0;
      diff_pecl <= '0;
      src_aux_status <= 4'h0;
    end else begin
      main_fwd_clk <= sif[S_MAIN_FWD].acc[ACC_W-1];
      main_fb_clk <= main_fb_acc[ACC_W-1];
      aux_fwd_clk <= sif[S_AUX_FWD].acc[ACC_W-1];
      aux_fb_clk <= sif[S_AUX_FWD].acc[ACC_W-1];
      frame_sync_out <= fs_active ^ fs_invert;
      multiframe_sync_out <= mfs_active ^ mfs_invert;
      lowrate_8k_out <= sif[S_LOWRATE].acc[ACC_W-1];
      lowrate_2k_out <= lr_div_reg[1];
      dig1_clk <= sif[S_DIG1].acc[ACC_W-1];
      dig1_edge_phase <= sif[S_DIG1].phase;
      dig2_clk <= sif[S_DIG2].acc[ACC_W-1];
      main_apll_ref <= sif[S_APLL_MAIN].acc[ACC_W-1];
      main_apll2_ref <= sif[S_APLL_MAIN2].acc[ACC_W-1];
      aux_apll_ref <= sif[S_APLL_AUX].acc[ACC_W-1] && !ax_off;
      aux_apll_pwr_dn <= ax_off;
      diff_p <= diff_src & fmt_on;
      diff_n <= ~diff_src & fmt_on;
      diff_en <= fmt_on;
      diff_pecl <= fmt_pecl;
      src_aux_status <= {sif[S_APLL_AUX].src_aux_eff,
        sif[S_DIG2].src_aux_eff, sif[S_DIG1].src_aux_eff,
        sif[S_LOWRATE].src_aux_eff};
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_s_n);

  sequence s_fs_two_wide;
    fs_active ##1 fs_active ##1 !fs_active;
  endsequence

  chk_fs_pulse_width: assert property (
    fs_wrap && fs_width == 8'h02 |=> s_fs_two_wide)
    else $error("frame sync pulse width wrong");

  chk_fs_polarity: assert property (
    fs_active |=> frame_sync_out != $past(fs_invert))
    else $error("frame sync polarity wrong");

  chk_mf_fourth_frame: assert property (
    fs_wrap && frame_cnt_reg != MF_LAST && !mfs_active |=> !mfs_active)
    else $error("multiframe pulse off the fourth frame");

  chk_lock_forces_main: assert property (
    lr_wrap && $past(lock_aux_to_main) |-> !sif[S_LOWRATE].src_aux_eff)
    else $error("lock to main ignored");

  chk_fs_main_only: assert property (
    fs_wrap && !$past(framesync_independent)
    |-> !sif[S_FRAME_SYNC_OUT].src_aux_eff)
    else $error("frame sync synth left main path");

  chk_apll_main_fixed: assert property (
    !sif[S_APLL_MAIN].src_aux_eff && !sif[S_APLL_MAIN2].src_aux_eff)
    else $error("main apll reference left main path");

  chk_aux_apll_off: assert property (
    ax_off |=> aux_apll_pwr_dn && !aux_apll_ref)
    else $error("aux apll not powered down");

  chk_diff_off: assert property (
    diff_output_format_sel[1:0] == FMT_OFF
    |=> !diff_en[0] && !diff_p[0] && !diff_n[0])
    else $error("disabled differential output driven");

  chk_fb_zero_offset: assert property (
    main_phase_offset == '0 && $past(main_phase_offset) == '0
    |-> main_fb_clk == main_fwd_clk)
    else $error("feedback differs with zero offset");

endmodule

// File: ocs_output_clock_synth_tb_top.sv
// self-checking bench of the output clock synthesis and routing block
// assumes ocs_clk_rx stands for the receivers of the output clocks
`timescale 1ns/100ps
module ocs_output_clock_synth_tb_top
  import ocs_pkg::*;
;
  typedef struct {
    logic f1; logic [1:0] m1; logic a2; logic f2; logic [1:0] m2;
    int k1; int k2;
  } ocs_tb_row_t;
  logic clk_sys = 1'b0;
  logic rst_n;
  logic signed [ADJ_W-1:0] main_path_adj, aux_path_adj;
  logic [ACC_W-1:0] main_phase_offset, main_apll_inc, main_apll2_inc;
  logic [ACC_W-1:0] aux_apll_inc;
  logic lock_aux_to_main, framesync_independent, lowrate_synth_source;
  logic digrate_one_source, digrate_two_source, aux_apll_to_main;
  logic digrate_one_family, digrate_two_alt_freq, digrate_two_family;
  logic [1:0] digrate_one_multiplier, digrate_two_multiplier;
  logic [3:0] aux_apll_freq_sel;
  logic [7:0] fs_width, mfs_width;
  logic fs_invert, mfs_invert;
  logic [2*NDIFF-1:0] diff_output_format_sel;
  logic main_fwd_clk, main_fb_clk, aux_fwd_clk, aux_fb_clk;
  logic frame_sync_out, multiframe_sync_out, lowrate_8k_out, lowrate_2k_out;
  logic dig1_clk, dig2_clk, main_apll_ref, main_apll2_ref, aux_apll_ref;
  logic [PH_W-1:0] dig1_edge_phase;
  logic aux_apll_pwr_dn;
  logic [NDIFF-1:0] diff_p, diff_n, diff_en, diff_pecl, en_x, pe_x;
  logic [3:0] src_aux_status;
  logic [8:0] lanes;
  logic clr;
  logic [15:0] rx_edges [9];
  logic [15:0] rx_min [9];
  logic [7:0] sels [4] = '{8'he4, 8'h1b, 8'h55, 8'haa};
  ocs_tb_row_t rows [12];
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  int fs_n = 0;
  int fs_t0, fs_t1, fs_w;
  logic fs_prev = 1'b0;

  assign lanes = {aux_apll_ref, main_apll2_ref, main_apll_ref, aux_fb_clk,
    aux_fwd_clk, main_fb_clk, main_fwd_clk, dig2_clk, dig1_clk};

  always #25 clk_sys = ~clk_sys;

  ocs_output_clock_synth dut (.clk_sys, .rst_n, .main_path_adj,
    .aux_path_adj, .main_phase_offset, .lock_aux_to_main,
    .framesync_independent, .lowrate_synth_source, .digrate_one_source,
    .digrate_two_source, .aux_apll_to_main, .digrate_one_family,
    .digrate_one_multiplier, .digrate_two_alt_freq, .digrate_two_family,
    .digrate_two_multiplier, .aux_apll_freq_sel, .main_apll_inc,
    .main_apll2_inc, .aux_apll_inc, .fs_width, .fs_invert, .mfs_width,
    .mfs_invert, .diff_output_format_sel, .main_fwd_clk, .main_fb_clk,
    .aux_fwd_clk, .aux_fb_clk, .frame_sync_out, .multiframe_sync_out,
    .lowrate_8k_out, .lowrate_2k_out, .dig1_clk, .dig1_edge_phase,
    .dig2_clk, .main_apll_ref, .main_apll2_ref, .aux_apll_ref,
    .aux_apll_pwr_dn, .diff_p, .diff_n, .diff_en, .diff_pecl,
    .src_aux_status);

  ocs_clk_rx #(.NL(9)) rx (.clk_sys(clk_sys), .clk_in(lanes), .clr(clr),
    .edges(rx_edges), .min_run(rx_min));

  task automatic end_sim;
    if (fails == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask

  // edge count within one edge of khz/100 over a 2048-cycle window
  task automatic near(input string nm, input int lane, input int khz);
    int g;
    g = rx_edges[lane];
    check_count++;
    if (g * 100 + 100 < khz || g * 100 > khz + 100) begin
      $display("Error %s expected %0d seen %0d", nm, khz / 100, g);
      fails++;
    end
  endtask

  task automatic measure;
    @(negedge clk_sys) clr = 1'b1;
    @(negedge clk_sys) clr = 1'b0;
    repeat (2048) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // frame sync watcher, active low pulses
  always @(posedge clk_sys) begin
    cyc++;
    if (fs_prev === 1'b1 && frame_sync_out === 1'b0) begin
      if (fs_n == 0) fs_t0 = cyc;
      if (fs_n == 1) fs_t1 = cyc;
      fs_n++;
      fs_w = 0;
    end
    if (frame_sync_out === 1'b0) fs_w++;
    if (fs_prev === 1'b0 && frame_sync_out === 1'b1 && fs_n > 0)
      chk("fs_width", 32'(fs_width), fs_w);
    fs_prev = frame_sync_out;
    if (cyc == 90000) begin
      fails++;
      end_sim();
    end
  end

  initial begin
    rst_n = 1'b0;
    clr = 1'b0;
    main_path_adj = 16'sh0100;
    aux_path_adj = 16'sh0400;
    main_phase_offset = 32'h8000_0000;
    main_apll_inc = 32'h0800_0000;
    main_apll2_inc = 32'h1000_0000;
    aux_apll_inc = 32'h0400_0000;
    lock_aux_to_main = 1'b0;
    framesync_independent = 1'b0;
    lowrate_synth_source = 1'b1;
    digrate_one_source = 1'b1;
    digrate_two_source = 1'b1;
    aux_apll_to_main = 1'b0;
    aux_apll_freq_sel = 4'h1;
    fs_width = 8'h02;
    fs_invert = 1'b1;
    mfs_width = 8'h07;
    mfs_invert = 1'b1;
    diff_output_format_sel = 8'h00;
    {digrate_one_family, digrate_one_multiplier} = 3'h0;
    {digrate_two_alt_freq, digrate_two_family} = 2'h0;
    digrate_two_multiplier = 2'h0;
    rows = '{'{0,0,1,0,0,2048,6312}, '{0,1,1,0,2,4096,10000},
      '{0,2,1,1,0,8192,19440}, '{0,3,1,1,1,16384,38880},
      '{1,0,0,0,0,1544,2048}, '{1,1,0,0,1,3088,4096},
      '{1,2,0,0,2,6176,8192}, '{1,3,0,0,3,12352,16384},
      '{1,3,0,1,0,12352,1544}, '{1,2,0,1,1,6176,3088},
      '{0,1,0,1,2,4096,6176}, '{0,0,0,1,3,2048,12352}};
    repeat (2) @(negedge clk_sys);
    chk("reset_outs", 32'h0, {main_fwd_clk, aux_fwd_clk, dig1_clk,
      dig2_clk, frame_sync_out, diff_en, src_aux_status, aux_apll_pwr_dn});
    rst_n = 1'b1;
    repeat (12) @(negedge clk_sys);
    chk("sync_idle", 32'h3, {frame_sync_out, multiframe_sync_out});
    chk("apll_pwr_dn", 32'h0, aux_apll_pwr_dn);
    for (int i = 0; i < 12; i++) begin
      digrate_one_family = rows[i].f1;
      digrate_one_multiplier = rows[i].m1;
      digrate_two_alt_freq = rows[i].a2;
      digrate_two_family = rows[i].f2;
      digrate_two_multiplier = rows[i].m2;
      repeat (20) @(negedge clk_sys);
      measure();
      near("dig1_rate", 0, rows[i].k1);
      near("dig2_rate", 1, rows[i].k2);
      chk("aux_fb", 32'(aux_fwd_clk), 32'(aux_fb_clk));
    end
    near("main_fwd", 2, 19440);
    near("main_fb", 3, 19440);
    near("aux_fwd", 4, 19440);
    near("aux_fb_rate", 5, 19440);
    near("apll_main", 6, 6400);
    near("apll_main2", 7, 12800);
    near("apll_aux", 8, 3200);
    chk("fb_offset", !main_fwd_clk, main_fb_clk);
    check_count++;
    if (dig1_edge_phase > INC_E1[0][31:24]
        || $isunknown(dig1_edge_phase)) begin
      $display("Error dig1_edge_phase expected low seen %h", dig1_edge_phase);
      fails++;
    end
    main_phase_offset = 32'h0;
    repeat (2) @(negedge clk_sys);
    chk("fb_zero", main_fwd_clk, main_fb_clk);
    for (int k = 0; k < 30000 && src_aux_status !== 4'hf; k++)
      @(negedge clk_sys);
    chk("src_all_aux", 32'hf, src_aux_status);
    lock_aux_to_main = 1'b1;
    @(negedge clk_sys) clr = 1'b1;
    @(negedge clk_sys) clr = 1'b0;
    for (int k = 0; k < 30000 && src_aux_status !== 4'h0; k++)
      @(negedge clk_sys);
    chk("src_locked", 32'h0, src_aux_status);
    check_count++;
    if (rx_min[0] < 16'h0030 || $isunknown(rx_min[0])) begin
      $display("Error dig1_min_run expected 48 seen %0d", rx_min[0]);
      fails++;
    end
    lock_aux_to_main = 1'b0;
    aux_apll_freq_sel = AUX_APLL_OFF;
    repeat (10) @(negedge clk_sys);
    chk("apll_off", 32'h1, aux_apll_pwr_dn);
    measure();
    chk("apll_off_edges", 32'h0, rx_edges[8]);
    chk("apll_off_lvl", 32'h0, aux_apll_ref);
    aux_apll_to_main = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk("apll_on", 32'h0, aux_apll_pwr_dn);
    for (int s = 0; s < 4; s++) begin
      diff_output_format_sel = sels[s];
      for (int n = 0; n < NDIFF; n++) begin
        en_x[n] = sels[s][2*n +: 2] inside {FMT_LVDS, FMT_PECL};
        pe_x[n] = sels[s][2*n +: 2] == FMT_PECL;
      end
      repeat (5) @(negedge clk_sys);
      chk("diff_en", en_x, diff_en);
      chk("diff_pecl", pe_x, diff_pecl);
      chk("diff_off", 32'h0, (diff_p | diff_n) & ~diff_en);
    end
    for (int k = 0; k < 60000 && fs_n < 2; k++)
      @(negedge clk_sys);
    check_count++;
    if (fs_n < 2 || fs_t1 - fs_t0 < 25599 || fs_t1 - fs_t0 > 25601) begin
      $display("Error fs_period expected 25600 seen %0d", fs_t1 - fs_t0);
      fails++;
    end
    chk("lowrate_2k", 32'h1, lowrate_2k_out);
    chk("lowrate_8k", 32'h0, lowrate_8k_out);
    end_sim();
  end
endmodule

// File: ocs_pkg.sv
// constants for the output clock synthesis and routing block
// assumes the system clock stands in for the master synthesis clock
package ocs_pkg;

  localparam int ACC_W = 32;
  localparam int ADJ_W = 16;
  localparam int PH_W = 8;
  localparam int ADJ_SHIFT = 24;
  localparam int NSYN = 9;
  localparam int NDIFF = 4;

  // synthesizer slots
  localparam int S_MAIN_FWD = 0;
  localparam int S_AUX_FWD = 1;
  localparam int S_FRAME_SYNC_OUT = 2;
  localparam int S_LOWRATE = 3;
  localparam int S_DIG1 = 4;
  localparam int S_DIG2 = 5;
  localparam int S_APLL_MAIN = 6;
  localparam int S_APLL_MAIN2 = 7;
  localparam int S_APLL_AUX = 8;

  // master clock rate and increment scaling
  localparam longint MASTER_HZ = 64'd204800000;
  localparam longint FS_HZ = 64'd8000;
  localparam longint PATH_HZ = 64'd19440000;

  localparam logic [ACC_W-1:0] INC_FS = 32'((FS_HZ << 32) / MASTER_HZ);
  localparam logic [ACC_W-1:0] INC_PATH = 32'((PATH_HZ << 32) / MASTER_HZ);

  // e1 family, multiplier codes 00..11
  localparam logic [ACC_W-1:0] INC_E1 [4] = '{
    32'((64'd2048000 << 32) / MASTER_HZ),
    32'((64'd4096000 << 32) / MASTER_HZ),
    32'((64'd8192000 << 32) / MASTER_HZ),
    32'((64'd16384000 << 32) / MASTER_HZ)};
  // ds1 family, multiplier codes 00..11
  localparam logic [ACC_W-1:0] INC_DS1 [4] = '{
    32'((64'd1544000 << 32) / MASTER_HZ),
    32'((64'd3088000 << 32) / MASTER_HZ),
    32'((64'd6176000 << 32) / MASTER_HZ),
    32'((64'd12352000 << 32) / MASTER_HZ)};
  // alternate set of the second digital-rate synthesizer
  localparam logic [ACC_W-1:0] INC_6312 = 32'((64'd6312000 << 32) / MASTER_HZ);
  localparam logic [ACC_W-1:0] INC_10M = 32'((64'd10000000 << 32) / MASTER_HZ);
  localparam logic [ACC_W-1:0] INC_1944 = 32'((64'd19440000 << 32) / MASTER_HZ);
  localparam logic [ACC_W-1:0] INC_3888 = 32'((64'd38880000 << 32) / MASTER_HZ);

  // differential output format codes
  localparam logic [1:0] FMT_OFF = 2'h0;
  localparam logic [1:0] FMT_LVDS = 2'h1;
  localparam logic [1:0] FMT_PECL = 2'h2;

  localparam logic [3:0] AUX_APLL_OFF = 4'h0;
  localparam logic [1:0] MF_LAST = 2'h3;
  localparam logic [ACC_W-1:0] ACC_RST = 32'h0;

endpackage

// File: ocs_synth_if.sv
// control and result bundle of one phase-accumulator synthesizer
// assumes one driver of controls (the top) and one synthesizer
`timescale 1ns/100ps
interface ocs_synth_if;
  import ocs_pkg::*;
  logic [ACC_W-1:0] nominal;
  logic signed [ADJ_W-1:0] main_adj;
  logic signed [ADJ_W-1:0] aux_adj;
  logic src_aux_req;
  logic hold;
  logic [ACC_W-1:0] acc;
  logic wrap;
  logic [PH_W-1:0] phase;
  logic src_aux_eff;
  modport synth (input nominal, main_adj, aux_adj, src_aux_req, hold,
    output acc, wrap, phase, src_aux_eff);
  modport ctl (output nominal, main_adj, aux_adj, src_aux_req, hold,
    input acc, wrap, phase, src_aux_eff);
endinterface
